// file: fhmr_flag_latch.sv
// one sticky fault flag register with condition-gated clear
`timescale 1ns/1ps
module fhmr_flag_latch
  import fhmr_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // live fault conditions and clear strobe
  input wire fhmr_pkg::fhmr_flags_t cond,
  input wire logic clear,
  // latched flags
  output fhmr_pkg::fhmr_flags_t flags
);
  import fhmr_pkg::*;

  fhmr_flags_t flags_r;
  fhmr_flags_t flags_nxt;
  always_comb
  begin
    // a live condition always sets, so it also wins over a clear
    if (clear)
      flags_nxt = cond;
    else
      flags_nxt = flags_r | cond;
  end
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      flags_r <= FLAG_RST;
    else
      flags_r <= flags_nxt;
  end
  assign flags = flags_r;
endmodule

// file: fhmr_group_or.sv
// reduces a run of low-level flag registers to one group-active bit
`timescale 1ns/1ps
module fhmr_group_or
  import fhmr_pkg::*;
#(
  parameter int N = 1
)
(
  // registers of the group
  input wire fhmr_pkg::fhmr_flags_t regs [N],
  // any flag set in the group
  output logic active
);
  import fhmr_pkg::*;

  always_comb
  begin
    active = 1'b0;
    for (int i = 0; i < N; i++)
      active = active | (|regs[i]);
  end
endmodule

// file: fhmr_host.sv
// host model: polls the summary, fetches a group register behind it
`timescale 1ns/1ps
module fhmr_host
  import fhmr_pkg::*;
(
  // clock and poll request
  input wire logic clock,
  input wire logic poll,
  // device status
  input wire logic [7:0] fault_summary,
  input wire logic fault_alert_pin_n,
  input wire fhmr_pkg::fhmr_flags_t otp_flags,
  // poll result, one cycle
  output logic rd_valid,
  output logic [7:0] rd_sum,
  output logic rd_pin_n,
  output fhmr_pkg::fhmr_flags_t rd_otp
);
  always @(posedge clock)
  begin
    rd_valid <= poll;
    rd_sum <= fault_summary;
    rd_pin_n <= fault_alert_pin_n;
    // saves bus traffic: quiet groups are never read
    rd_otp <= fault_summary[SUM_OTP] ? otp_flags : 8'h00;
  end
endmodule

// file: fhmr_monitor.sv
// checker: port-level properties of the fault hierarchy block
`timescale 1ns/1ps
module fhmr_monitor
  import fhmr_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // stimulus
  input wire fhmr_pkg::fhmr_flags_t fault_cond [fhmr_pkg::NUM_REGS],
  input wire fhmr_pkg::fhmr_flags_t debug_cond [fhmr_pkg::NUM_DBG],
  input wire logic mask_a_we,
  input wire logic mask_b_we,
  input wire logic clear_a_we,
  input wire logic [7:0] clear_a_wdata,
  input wire logic clear_b_we,
  input wire logic [7:0] clear_b_wdata,
  input wire logic alert_pin_enable,
  // outputs
  input wire fhmr_pkg::fhmr_flags_t fault_flags [fhmr_pkg::NUM_REGS],
  input wire fhmr_pkg::fhmr_flags_t link_detail_flags [fhmr_pkg::NUM_DBG],
  input wire logic [7:0] group_mask_reg_a,
  input wire logic [7:0] group_mask_reg_b,
  input wire logic [7:0] fault_summary,
  input wire logic fault_alert_pin_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  wire logic clr_ot = clear_a_we && clear_a_wdata[MA_OT];
  wire logic clr_otp = clear_b_we && clear_b_wdata[MB_OTP];
  // pin enable sampled, then summary shows a fault
  sequence s_alert;
    alert_pin_enable ##1 fault_summary != 8'h00;
  endsequence
  sequence s_otp_live;
    fault_flags[B_OTP] != 8'h00 && !group_mask_reg_b[MB_OTP] && !mask_b_we;
  endsequence
  AST_SET: assert property
    (fault_cond[B_PWR][0] |=> fault_flags[B_PWR][0])
    else $error("flag did not latch");
  AST_HOLD: assert property
    (fault_flags[B_OT][0] && !clr_ot |=> fault_flags[B_OT][0])
    else $error("flag dropped without clear");
  AST_LIVE: assert property
    (clr_ot && fault_cond[B_OT][0] |=> fault_flags[B_OT][0])
    else $error("clear took a live flag");
  AST_CLR: assert property
    (clr_ot && fault_cond[B_OT] == 8'h00 |=> fault_flags[B_OT] == 8'h00)
    else $error("clear ignored");
  AST_DBG: assert property
    (clr_otp && debug_cond[D_OTP] == 8'h00 |=>
     link_detail_flags[D_OTP] == 8'h00)
    else $error("detail flags not cleared");
  AST_SUM: assert property
    (s_otp_live |=> fault_summary[SUM_OTP])
    else $error("summary bit missing");
  AST_MASK: assert property
    (group_mask_reg_b[MB_OTP] && !mask_b_we |=> !fault_summary[SUM_OTP])
    else $error("masked group in summary");
  AST_TEMP: assert property
    (group_mask_reg_a[MA_UT:MA_OT] == 2'h3 && !mask_a_we |=>
     !fault_summary[SUM_OTUT])
    else $error("temperature group not masked");
  AST_COMM: assert property
    (fault_flags[B_COMM+2] != 8'h00 && !group_mask_reg_b[MB_COMM]
     && !mask_b_we |=> fault_summary[SUM_COMM])
    else $error("link summary cleared early");
  AST_QUIET: assert property
    (fault_summary == 8'h00 |-> fault_alert_pin_n)
    else $error("pin low without summary");
  AST_PIN_OFF: assert property
    (!alert_pin_enable |=> fault_alert_pin_n)
    else $error("pin low while disabled");
  AST_PIN_ON: assert property
    (s_alert |-> !fault_alert_pin_n)
    else $error("pin not asserted");
endmodule
bind fhmr_top fhmr_monitor mon (.clock, .rstn, .fault_cond, .debug_cond,
  .mask_a_we, .mask_b_we, .clear_a_we, .clear_a_wdata, .clear_b_we,
  .clear_b_wdata, .alert_pin_enable, .fault_flags, .link_detail_flags,
  .group_mask_reg_a, .group_mask_reg_b, .fault_summary, .fault_alert_pin_n);

// file: fhmr_pkg.sv
// package: group layout, mask and clear register fields, flag widths
package fhmr_pkg;
  // summary bit positions, one per fault group
  localparam int SUM_PWR = 0;
  localparam int SUM_SYS = 1;
  localparam int SUM_OVUV = 2;
  localparam int SUM_OTUT = 3;
  localparam int SUM_COMM = 4;
  localparam int SUM_OTP = 5;
  localparam int SUM_COMP = 6;
  localparam int SUM_PROT = 7;
  localparam int NUM_GROUPS = 8;
  // low-level register counts per group
  localparam int N_PWR = 3;
  localparam int N_SYS = 1;
  localparam int N_OV = 2;
  localparam int N_UV = 2;
  localparam int N_COMM = 3;
  localparam int N_OTP = 1;
  localparam int N_COMP = 11;
  localparam int N_PROT = 1;
  localparam int NUM_REGS = N_PWR + N_SYS + N_OV + N_UV + 2 + N_COMM
    + N_OTP + N_COMP + N_PROT;
  // base index of each group in the flat register array
  localparam int B_PWR = 0;
  localparam int B_SYS = B_PWR + N_PWR;
  localparam int B_OV = B_SYS + N_SYS;
  localparam int B_UV = B_OV + N_OV;
  localparam int B_OT = B_UV + N_UV;
  localparam int B_UT = B_OT + 1;
  localparam int B_COMM = B_UT + 1;
  localparam int B_OTP = B_COMM + N_COMM;
  localparam int B_COMP = B_OTP + N_OTP;
  localparam int B_PROT = B_COMP + N_COMP;
  // mask/clear register a fields
  localparam int MA_PWR = 0;
  localparam int MA_SYS = 1;
  localparam int MA_OV = 2;
  localparam int MA_UV = 3;
  localparam int MA_OT = 4;
  localparam int MA_UT = 5;
  localparam int MA_PROT = 6;
  localparam int MA_COMP = 7;
  // mask/clear register b fields
  localparam int MB_COMM = 0;
  localparam int MB_OTP = 1;
  // debug registers: two under link errors, one under otp
  localparam int NUM_DBG = 3;
  localparam int D_COMM_A = 0;
  localparam int D_COMM_B = 1;
  localparam int D_OTP = 2;
  // low-level register index owning each debug register
  localparam int DBG_PARENT [NUM_DBG] = '{B_COMM, B_COMM + 1, B_OTP};
  localparam int FLAG_W = 8;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] SUM_RST = 8'h00;
  localparam logic ALERT_N_RST = 1'b1;
  typedef logic [FLAG_W-1:0] fhmr_flags_t;
  localparam fhmr_flags_t FLAG_RST = 8'h00;
endpackage

// file: fhmr_top.sv
// fault hierarchy: latched flags, group summary, masks, clears, alert pin
`timescale 1ns/1ps
module fhmr_top
  import fhmr_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // live fault conditions, one word per low-level register
  input wire fhmr_pkg::fhmr_flags_t fault_cond [fhmr_pkg::NUM_REGS],
  // live conditions behind the debug registers
  input wire fhmr_pkg::fhmr_flags_t debug_cond [fhmr_pkg::NUM_DBG],
  // mask register writes
  input wire logic mask_a_we,
  input wire logic [7:0] mask_a_wdata,
  input wire logic mask_b_we,
  input wire logic [7:0] mask_b_wdata,
  // clear register writes, bits self-clear
  input wire logic clear_a_we,
  input wire logic [7:0] clear_a_wdata,
  input wire logic clear_b_we,
  input wire logic [7:0] clear_b_wdata,
  // alert pin configuration
  input wire logic alert_pin_enable,
  // status readback
  output fhmr_pkg::fhmr_flags_t fault_flags [fhmr_pkg::NUM_REGS],
  output fhmr_pkg::fhmr_flags_t link_detail_flags [fhmr_pkg::NUM_DBG],
  output logic [7:0] group_mask_reg_a,
  output logic [7:0] group_mask_reg_b,
  output logic [7:0] fault_summary,
  // active-low fault alert pin
  output logic fault_alert_pin_n
);
  import fhmr_pkg::*;

  logic [7:0] mask_a_r;
  logic [7:0] mask_a_nxt;
  logic [7:0] mask_b_r;
  logic [7:0] mask_b_nxt;
  logic [7:0] summary_r;
  logic [7:0] summary_nxt;
  logic alert_n_r;
  logic alert_n_nxt;
  logic [NUM_REGS-1:0] reg_clear;
  logic [NUM_DBG-1:0] dbg_clear;
  logic [7:0] clr_a;
  logic [7:0] clr_b;
  logic [7:0] grp_active;
  logic [7:0] grp_masked;
  logic ov_act;
  logic uv_act;
  logic ot_act;
  logic ut_act;

  // clear strobes apply only in the write cycle; the clear registers
  // read as zero, so no state is kept for them
  assign clr_a = clear_a_we ? clear_a_wdata : 8'h00;
  assign clr_b = clear_b_we ? clear_b_wdata : 8'h00;

  function automatic logic in_range(input int i, input int b, input int n);
    in_range = (i >= b) && (i < b + n);
  endfunction

  // clear bit owning a given low-level register, same layout as masks
  always_comb
  begin
    for (int i = 0; i < NUM_REGS; i++)
    begin
      reg_clear[i] = 1'b0;
      if (in_range(i, B_PWR, N_PWR))
        reg_clear[i] = clr_a[MA_PWR];
      if (in_range(i, B_SYS, N_SYS))
        reg_clear[i] = clr_a[MA_SYS];
      if (in_range(i, B_OV, N_OV))
        reg_clear[i] = clr_a[MA_OV];
      if (in_range(i, B_UV, N_UV))
        reg_clear[i] = clr_a[MA_UV];
      if (i == B_OT)
        reg_clear[i] = clr_a[MA_OT];
      if (i == B_UT)
        reg_clear[i] = clr_a[MA_UT];
      if (in_range(i, B_PROT, N_PROT))
        reg_clear[i] = clr_a[MA_PROT];
      if (in_range(i, B_COMP, N_COMP))
        reg_clear[i] = clr_a[MA_COMP];
      if (in_range(i, B_COMM, N_COMM))
        reg_clear[i] = clr_b[MB_COMM];
      if (in_range(i, B_OTP, N_OTP))
        reg_clear[i] = clr_b[MB_OTP];
    end
    for (int d = 0; d < NUM_DBG; d++)
      dbg_clear[d] = reg_clear[DBG_PARENT[d]];
  end

  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++)
    begin : g_low
      fhmr_flag_latch u_latch (
        .clock(clock),
        .rstn(rstn),
        .cond(fault_cond[g]),
        .clear(reg_clear[g]),
        .flags(fault_flags[g])
      );
    end
    for (g = 0; g < NUM_DBG; g++)
    begin : g_dbg
      fhmr_flag_latch u_latch (
        .clock(clock),
        .rstn(rstn),
        .cond(debug_cond[g]),
        .clear(dbg_clear[g]),
        .flags(link_detail_flags[g])
      );
    end
  endgenerate

  // group reductions over the latched low-level registers
  fhmr_group_or #(.N(N_PWR)) u_pwr (
    .regs(fault_flags[B_PWR +: N_PWR]),
    .active(grp_active[SUM_PWR])
  );
  fhmr_group_or #(.N(N_SYS)) u_sys (
    .regs(fault_flags[B_SYS +: N_SYS]),
    .active(grp_active[SUM_SYS])
  );
  fhmr_group_or #(.N(N_OV)) u_ov (
    .regs(fault_flags[B_OV +: N_OV]),
    .active(ov_act)
  );
  fhmr_group_or #(.N(N_UV)) u_uv (
    .regs(fault_flags[B_UV +: N_UV]),
    .active(uv_act)
  );
  fhmr_group_or #(.N(N_COMM)) u_comm (
    .regs(fault_flags[B_COMM +: N_COMM]),
    .active(grp_active[SUM_COMM])
  );
  fhmr_group_or #(.N(N_OTP)) u_otp (
    .regs(fault_flags[B_OTP +: N_OTP]),
    .active(grp_active[SUM_OTP])
  );
  fhmr_group_or #(.N(N_COMP)) u_comp (
    .regs(fault_flags[B_COMP +: N_COMP]),
    .active(grp_active[SUM_COMP])
  );
  fhmr_group_or #(.N(N_PROT)) u_prot (
    .regs(fault_flags[B_PROT +: N_PROT]),
    .active(grp_active[SUM_PROT])
  );
  assign ot_act = |fault_flags[B_OT];
  assign ut_act = |fault_flags[B_UT];
  // merged halves; the gated form below is what reaches the summary
  assign grp_active[SUM_OVUV] = ov_act | uv_act;
  assign grp_active[SUM_OTUT] = ot_act | ut_act;

  // per-group gating; the voltage and temperature summaries each merge
  // two masked subgroups, so a single mask bit only hides its own half
  always_comb
  begin
    grp_masked = 8'h00;
    grp_masked[SUM_PWR] = grp_active[SUM_PWR] & ~mask_a_r[MA_PWR];
    grp_masked[SUM_SYS] = grp_active[SUM_SYS] & ~mask_a_r[MA_SYS];
    grp_masked[SUM_OVUV] = (ov_act & ~mask_a_r[MA_OV])
      | (uv_act & ~mask_a_r[MA_UV]);
    grp_masked[SUM_OTUT] = (ot_act & ~mask_a_r[MA_OT])
      | (ut_act & ~mask_a_r[MA_UT]);
    grp_masked[SUM_COMM] = grp_active[SUM_COMM] & ~mask_b_r[MB_COMM];
    grp_masked[SUM_OTP] = grp_active[SUM_OTP] & ~mask_b_r[MB_OTP];
    grp_masked[SUM_COMP] = grp_active[SUM_COMP] & ~mask_a_r[MA_COMP];
    grp_masked[SUM_PROT] = grp_active[SUM_PROT] & ~mask_a_r[MA_PROT];
  end

  // mask group: a write lands at its edge; the summary, built from the
  // registered masks, follows one edge later
  always_comb
  begin
    mask_a_nxt = mask_a_r;
    mask_b_nxt = mask_b_r;
    if (mask_a_we)
      mask_a_nxt = mask_a_wdata;
    if (mask_b_we)
      mask_b_nxt = mask_b_wdata;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      mask_a_r <= MASK_RST;
      mask_b_r <= MASK_RST;
    end
    else
    begin
      mask_a_r <= mask_a_nxt;
      mask_b_r <= mask_b_nxt;
    end
  end

  // summary group: read-only and rebuilt every cycle from latched flags,
  // so a bit drops only once every register of its group is clear or masked
  always_comb
  begin
    summary_nxt = grp_masked;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      summary_r <= SUM_RST;
    else
      summary_r <= summary_nxt;
  end

  // alert group: the pin enable gates only the pin, never the summary
  always_comb
  begin
    alert_n_nxt = ~(alert_pin_enable & (|grp_masked));
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      alert_n_r <= ALERT_N_RST;
    else
      alert_n_r <= alert_n_nxt;
  end

  assign group_mask_reg_a = mask_a_r;
  assign group_mask_reg_b = mask_b_r;
  assign fault_summary = summary_r;
  assign fault_alert_pin_n = alert_n_r;
endmodule

// file: tb_top.sv
// testbench: random faults, masks and clears against a flag model
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((e) !== (a)) begin bad_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb_top;
  import fhmr_pkg::*;
  typedef struct {logic [7:0] s; logic p; fhmr_flags_t o;} fhmr_exp_t;
  logic clock = 1'h0, rstn = 1'h0, poll = 1'h0, en = 1'h0;
  logic ma_we = 1'h0, mb_we = 1'h0, ca_we = 1'h0, cb_we = 1'h0;
  logic [7:0] ma_d = 8'h00, mb_d = 8'h00, ca_d = 8'h00, cb_d = 8'h00;
  logic [7:0] ma, mb, esum, sum, mra, mrb, rs;
  logic epin, pin_n, rdv, rp;
  fhmr_flags_t cond [NUM_REGS], dbg [NUM_DBG], f [NUM_REGS], d [NUM_DBG];
  fhmr_flags_t flags [NUM_REGS], det [NUM_DBG], otp;
  fhmr_exp_t q [$];
  fhmr_exp_t e;
  integer seed = 32'h23b2;
  int bad_count = 0, compares = 0, cycles = 0;
  wire logic [7:0] clr_a = ca_we ? ca_d : 8'h00;
  wire logic [7:0] clr_b = cb_we ? cb_d : 8'h00;
  fhmr_top dut (.clock, .rstn, .fault_cond(cond), .debug_cond(dbg),
    .mask_a_we(ma_we), .mask_a_wdata(ma_d), .mask_b_we(mb_we),
    .mask_b_wdata(mb_d), .clear_a_we(ca_we), .clear_a_wdata(ca_d),
    .clear_b_we(cb_we), .clear_b_wdata(cb_d), .alert_pin_enable(en),
    .fault_flags(flags), .link_detail_flags(det), .group_mask_reg_a(mra),
    .group_mask_reg_b(mrb), .fault_summary(sum), .fault_alert_pin_n(pin_n));
  fhmr_host host (.clock, .poll, .fault_summary(sum),
    .fault_alert_pin_n(pin_n), .otp_flags(flags[B_OTP]), .rd_valid(rdv),
    .rd_sum(rs), .rd_pin_n(rp), .rd_otp(otp));
  initial forever #5 clock = ~clock;
  function automatic int grp(int i);
    if (i < B_SYS) return SUM_PWR;
    if (i < B_OV) return SUM_SYS;
    if (i < B_OT) return SUM_OVUV;
    if (i < B_COMM) return SUM_OTUT;
    if (i < B_OTP) return SUM_COMM;
    if (i < B_COMP) return SUM_OTP;
    if (i < B_PROT) return SUM_COMP;
    return SUM_PROT;
  endfunction
  // mask and clear share one layout
  function automatic logic sel(int i, logic [7:0] a, logic [7:0] b);
    case (grp(i))
      SUM_PWR: return a[MA_PWR];
      SUM_SYS: return a[MA_SYS];
      SUM_OVUV: return i < B_UV ? a[MA_OV] : a[MA_UV];
      SUM_OTUT: return i == B_OT ? a[MA_OT] : a[MA_UT];
      SUM_COMM: return b[MB_COMM];
      SUM_OTP: return b[MB_OTP];
      SUM_COMP: return a[MA_COMP];
      default: return a[MA_PROT];
    endcase
  endfunction
  always @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      foreach (f[i]) f[i] = 8'h00;
      foreach (d[i]) d[i] = 8'h00;
      {ma, mb, esum, epin} = {24'h000000, 1'h1};
    end
    else
    begin
      esum = 8'h00;
      foreach (f[i])
        if (f[i] != 8'h00 && !sel(i, ma, mb))
          esum[grp(i)] = 1'h1;
      epin = !(en && esum != 8'h00);
      foreach (d[i])
        d[i] = dbg[i]
          | (sel(DBG_PARENT[i], clr_a, clr_b) ? 8'h00 : d[i]);
      foreach (f[i])
        f[i] = cond[i] | (sel(i, clr_a, clr_b) ? 8'h00 : f[i]);
      if (ma_we) ma = ma_d;
      if (mb_we) mb = mb_d;
    end
  always @(negedge clock)
    if (rdv === 1'h1 && q.size() > 0)
    begin
      e = q.pop_front();
      `CHK("summary", e.s, rs)
      `CHK("pin", e.p, rp)
      `CHK("otp read", e.o, otp)
      `CHK("mask a", ma, mra)
      `CHK("mask b", mb, mrb)
      foreach (f[i]) `CHK("flags", f[i], flags[i])
      foreach (d[i]) `CHK("detail", d[i], det[i])
    end
  task automatic poll_once;
    q.push_back('{esum, epin, esum[SUM_OTP] ? f[B_OTP] : 8'h00});
    poll = 1'h1;
    @(negedge clock);
    poll = 1'h0;
  endtask
  task automatic end_of_test;
    $display("counts: %0d compares, %0d mismatches", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      end_of_test;
    end
  end
  initial
  begin
    foreach (cond[i]) cond[i] = 8'h00;
    foreach (dbg[i]) dbg[i] = 8'h00;
    repeat (10) @(negedge clock);
    rstn = 1'h1;
    poll_once;
    $display("test reset done");
    for (int k = 0; k < 300; k++)
    begin
      foreach (cond[i]) cond[i] = ($random(seed) & 3) == 0 ? $random(seed) : 0;
      foreach (dbg[i]) dbg[i] = ($random(seed) & 1) ? $random(seed) : 0;
      {ma_we, mb_we, ca_we, cb_we, en} = $random(seed);
      {ma_d, mb_d} = $random(seed) & $random(seed);
      {ca_d, cb_d} = $random(seed);
      @(negedge clock);
      {ma_we, mb_we, ca_we, cb_we} = 4'h0;
      foreach (cond[i]) cond[i] = ($random(seed) & 7) == 0 ? cond[i] : 0;
      // a second reset in mid-run, kept off the edge of a poll check: the
      // model clears at once, the design only in its nonblocking update
      rstn = k != 150;
      @(negedge clock);
      rstn = 1'h1;
      @(negedge clock);
      poll_once;
    end
    $display("test random done");
    repeat (2) @(negedge clock);
    end_of_test;
  end
endmodule
